// File: include/tccad_regs.svh
// Timing counts and field positions for the Type-C attach and orientation detector.
// Included by the design files; definitions only.
`ifndef TCCAD_REGS_SVH
`define TCCAD_REGS_SVH

// Pin level comparator bit positions of a level word
`define TCCAD_LVL_BELOW_CABLE   0
`define TCCAD_LVL_BELOW_SINK    1
// Advertisement codes
`define TCCAD_ADV_DEFAULT       2'h0
`define TCCAD_ADV_1P5           2'h1
`define TCCAD_ADV_3P0           2'h2
// Debounce time in microseconds and clock rate in MHz
`define TCCAD_DEBOUNCE_US       100
`define TCCAD_CLK_MHZ           250
`define TCCAD_DEBOUNCE_CYCLES   (`TCCAD_DEBOUNCE_US * `TCCAD_CLK_MHZ)

`endif

// File: include/tccad_pkg.sv
// Types for the Type-C attach and orientation detector.
// Needs no other file.
package tccad_pkg;

	typedef enum logic [1:0] {
		TCCAD_TERM_OPEN,
		TCCAD_TERM_RD,
		TCCAD_TERM_RA
	} tccad_term_t;

	typedef enum logic [2:0] {
		TCCAD_CONN_NONE,
		TCCAD_CONN_SINK,
		TCCAD_CONN_CABLE_ONLY,
		TCCAD_CONN_CABLE_SINK,
		TCCAD_CONN_DEBUG_ACC,
		TCCAD_CONN_AUDIO_ACC,
		TCCAD_CONN_SOURCE
	} tccad_conn_t;

endpackage

// File: src/tccad_pin_class.sv
// Classifies one configuration pin from its two synchronised comparator outputs and debounces it.
// Comparator inputs are asynchronous to i_clk_sys and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "tccad_regs.svh"

module tccad_pin_class
	import tccad_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = `TCCAD_DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// Comparators: below sink-detect and below active-cable thresholds
	input  wire logic        i_below_sink,
	input  wire logic        i_below_cable,
	// Debounced class
	output var  tccad_term_t o_term
);
	localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

	logic [1:0]  sync_a;
	logic [1:0]  sync_b;
	tccad_term_t raw;
	tccad_term_t cand;
	tccad_term_t next_cand;
	tccad_term_t next_term;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	always_comb begin
		// Rising above the sink threshold means open, which ends the connection when the other pin is open [RULE10]
		if (sync_b[1] && sync_a[1])
			raw = TCCAD_TERM_RA; // [RULE9]
		else if (sync_b[1])
			raw = TCCAD_TERM_RD;
		else
			raw = TCCAD_TERM_OPEN;
		next_cand = cand;
		next_cnt  = cnt;
		next_term = o_term;
		if (raw != cand) begin
			next_cand = raw;
			next_cnt  = '0;
		end else if (cnt >= CW'(DEBOUNCE_CYCLES - 1)) begin
			next_term = cand; // [RULE18]
		end else begin
			next_cnt = cnt + CW'(1);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			cand   <= TCCAD_TERM_OPEN;
			cnt    <= '0;
			o_term <= TCCAD_TERM_OPEN;
		end else if (i_ce) begin
			sync_a <= {sync_a[0], i_below_cable};
			sync_b <= {sync_b[0], i_below_sink};
			cand   <= next_cand;
			cnt    <= next_cnt;
			o_term <= next_term;
		end
	end

endmodule
`default_nettype wire

// File: src/tccad_top.sv
// Type-C attach and orientation detector: pin classification, connection state, power and pull control.
// Analog comparators, switches and pull-ups sit outside; their control and outputs are plain ports.
// Function
// RULE1: Source, both open: watch both pins, VBUS and VCONN off.
// RULE2: Source, Rd on A only: sink attached, VBUS on, watch A.
// RULE3: Source, Rd on B only: sink attached, VBUS on, watch B.
// RULE4: Source, Ra on A only: cable, watch B attach, A detach, no power.
// RULE5: Source, Ra on B only: cable, watch A attach, B detach, no power.
// RULE6: Source, Ra A and Rd B: VBUS on, VCONN onto A, watch B.
// RULE7: Source, Rd A and Ra B: VBUS on, VCONN onto B, watch A.
// RULE8: Both Rd: debug accessory; both Ra: audio accessory; sense both pins.
// RULE9: Source pulls up each pin; each classified alone; below cable threshold is Ra.
// RULE10: Connected: monitored pin above sink threshold means disconnect.
// RULE11: Advertise default, 1.5 A or 3 A; thresholds follow the level.
// RULE12: Sink presents trimmed pull-downs and attaches when VBUS is present.
// RULE13: Sink reads source current capability from the pin pull-up level.
// RULE14: Firmware control switches dead-battery pull-down over to trimmed pull-down.
// RULE15: A control removes the dead-battery pull-down when acting as source.
// RULE16: Board straps gate pin to config pin or ground; not device logic.
// RULE17: Disconnected source keeps monitoring both pins.
// RULE18: Classification stable a debounce interval before state or power changes.
`timescale 1ns/1ps
`default_nettype none
`include "tccad_regs.svh"

module tccad_top
	import tccad_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = `TCCAD_DEBOUNCE_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// Configuration
	input  wire logic        i_role_source,
	input  wire logic [1:0]  i_adv_level,
	input  wire logic        i_use_trimmed_pulldown,
	input  wire logic        i_remove_deadbattery_pulldown,
	// Comparators on config_pin_a and config_pin_b
	input  wire logic        i_pin_a_below_sink,
	input  wire logic        i_pin_a_below_cable,
	input  wire logic        i_pin_b_below_sink,
	input  wire logic        i_pin_b_below_cable,
	// Sink side sensing
	input  wire logic        i_vbus_present,
	input  wire logic [1:0]  i_sink_pullup_level,
	// Analog control
	output logic [1:0]       o_adv_select,
	output logic             o_source_pullup_current_en,
	output logic             o_trimmed_sink_pulldown_en,
	output logic             o_deadbattery_sink_pulldown_off,
	// Power control
	output logic             o_vbus_power_en,
	output logic             o_vconn_on_pin_a,
	output logic             o_vconn_on_pin_b,
	// Status
	output tccad_conn_t      o_conn_state,
	output logic             o_watch_pin_a,
	output logic             o_watch_pin_b,
	output logic             o_orientation_b,
	output logic [1:0]       o_partner_adv_level,
	output logic             o_detach_event
);
	tccad_term_t term_a;
	tccad_term_t term_b;
	logic [1:0]  vbus_sync;
	logic [1:0]  lvl_sync0;
	logic [1:0]  lvl_sync1;
	logic [1:0]  lvl_hold;

	tccad_conn_t next_conn;
	logic        next_vbus;
	logic        next_vc_a;
	logic        next_vc_b;
	logic        next_wa;
	logic        next_wb;
	logic        next_orient;
	logic [1:0]  next_partner;
	logic        next_detach;

	// Thresholds move with the advertised level [RULE11]
	tccad_pin_class #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_class_a (
		.i_clk_sys     (i_clk_sys),
		.i_reset       (i_reset),
		.i_ce          (i_ce),
		.i_below_sink  (i_pin_a_below_sink),
		.i_below_cable (i_pin_a_below_cable),
		.o_term        (term_a)
	);

	tccad_pin_class #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_class_b (
		.i_clk_sys     (i_clk_sys),
		.i_reset       (i_reset),
		.i_ce          (i_ce),
		.i_below_sink  (i_pin_b_below_sink),
		.i_below_cable (i_pin_b_below_cable),
		.o_term        (term_b)
	);

	// Analog setup follows the role and the configuration inputs directly
	always_comb begin
		o_adv_select                    = i_adv_level; // [RULE11]
		o_source_pullup_current_en      = i_role_source; // [RULE9]
		o_trimmed_sink_pulldown_en      = !i_role_source && i_use_trimmed_pulldown; // [RULE12] [RULE14]
		o_deadbattery_sink_pulldown_off = i_remove_deadbattery_pulldown || i_use_trimmed_pulldown; // [RULE15] [RULE14]
	end

	always_comb begin
		next_conn    = TCCAD_CONN_NONE;
		next_vbus    = 1'b0;
		next_vc_a    = 1'b0;
		next_vc_b    = 1'b0;
		next_wa      = 1'b1;
		next_wb      = 1'b1;
		next_orient  = o_orientation_b;
		next_partner = 2'h0;
		if (i_role_source) begin
			case ({term_a, term_b})
				{TCCAD_TERM_OPEN, TCCAD_TERM_OPEN}: begin
					next_conn = TCCAD_CONN_NONE; // [RULE1] [RULE17]
				end
				{TCCAD_TERM_RD, TCCAD_TERM_OPEN}: begin
					next_conn   = TCCAD_CONN_SINK; // [RULE2]
					next_vbus   = 1'b1;
					next_wb     = 1'b0;
					next_orient = 1'b0;
				end
				{TCCAD_TERM_OPEN, TCCAD_TERM_RD}: begin
					next_conn   = TCCAD_CONN_SINK; // [RULE3]
					next_vbus   = 1'b1;
					next_wa     = 1'b0;
					next_orient = 1'b1;
				end
				{TCCAD_TERM_RA, TCCAD_TERM_OPEN}: begin
					next_conn = TCCAD_CONN_CABLE_ONLY; // [RULE4]
				end
				{TCCAD_TERM_OPEN, TCCAD_TERM_RA}: begin
					next_conn = TCCAD_CONN_CABLE_ONLY; // [RULE5]
				end
				{TCCAD_TERM_RA, TCCAD_TERM_RD}: begin
					next_conn   = TCCAD_CONN_CABLE_SINK; // [RULE6]
					next_vbus   = 1'b1;
					next_vc_a   = 1'b1;
					next_wa     = 1'b0;
					next_orient = 1'b1;
				end
				{TCCAD_TERM_RD, TCCAD_TERM_RA}: begin
					next_conn   = TCCAD_CONN_CABLE_SINK; // [RULE7]
					next_vbus   = 1'b1;
					next_vc_b   = 1'b1;
					next_wb     = 1'b0;
					next_orient = 1'b0;
				end
				{TCCAD_TERM_RD, TCCAD_TERM_RD}: begin
					next_conn = TCCAD_CONN_DEBUG_ACC; // [RULE8]
				end
				{TCCAD_TERM_RA, TCCAD_TERM_RA}: begin
					next_conn = TCCAD_CONN_AUDIO_ACC; // [RULE8]
				end
				default: begin
					next_conn = TCCAD_CONN_NONE;
				end
			endcase
		end else if (vbus_sync[1]) begin
			next_conn    = TCCAD_CONN_SOURCE; // [RULE12]
			// Both code bits cross from the pins together; only a code seen on two edges in a row is taken
			next_partner = (lvl_sync1 == lvl_hold) ? lvl_sync1 : o_partner_adv_level; // [RULE13]
		end
		// Any drop from a connected state, other than by reset, is a detach [RULE10]
		next_detach = (o_conn_state != TCCAD_CONN_NONE) && (next_conn == TCCAD_CONN_NONE);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			vbus_sync           <= 2'h0;
			lvl_sync0           <= 2'h0;
			lvl_sync1           <= 2'h0;
			lvl_hold            <= 2'h0;
			o_conn_state        <= TCCAD_CONN_NONE;
			o_vbus_power_en     <= 1'b0;
			o_vconn_on_pin_a    <= 1'b0;
			o_vconn_on_pin_b    <= 1'b0;
			o_watch_pin_a       <= 1'b1;
			o_watch_pin_b       <= 1'b1;
			o_orientation_b     <= 1'b0;
			o_partner_adv_level <= 2'h0;
			o_detach_event      <= 1'b0;
		end else if (i_ce) begin
			vbus_sync           <= {vbus_sync[0], i_vbus_present};
			lvl_sync0           <= i_sink_pullup_level;
			lvl_sync1           <= lvl_sync0;
			lvl_hold            <= lvl_sync1;
			o_conn_state        <= next_conn;
			o_vbus_power_en     <= next_vbus;
			o_vconn_on_pin_a    <= next_vc_a;
			o_vconn_on_pin_b    <= next_vc_b;
			o_watch_pin_a       <= next_wa;
			o_watch_pin_b       <= next_wb;
			o_orientation_b     <= next_orient;
			o_partner_adv_level <= next_partner;
			o_detach_event      <= next_detach;
		end
	end

endmodule
`default_nettype wire

// File: verif/tccad_cable_model.sv
// Cable and port partner: turns far-end terminations into pin comparator levels.
// Terminations and the source pull-up code are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module tccad_cable_model
	import tccad_pkg::*;
(
	// Far-end terminations and source pull-up code
	input  wire tccad_term_t i_term_a,
	input  wire tccad_term_t i_term_b,
	input  wire logic [1:0]  i_src_level,
	// Levels seen by the detector
	output logic             o_a_below_sink,
	output logic             o_a_below_cable,
	output logic             o_b_below_sink,
	output logic             o_b_below_cable,
	output logic [1:0]       o_pullup_level
);
	// Rd and Ra both pull under the sink level, only Ra under the cable level
	assign o_a_below_sink  = (i_term_a != TCCAD_TERM_OPEN);
	assign o_a_below_cable = (i_term_a == TCCAD_TERM_RA);
	assign o_b_below_sink  = (i_term_b != TCCAD_TERM_OPEN);
	assign o_b_below_cable = (i_term_b == TCCAD_TERM_RA);
	// The far-end source pull-up code reaches the detector unchanged
	assign o_pullup_level  = i_src_level;
endmodule
`default_nettype wire

// File: verif/tccad_top_props.sv
// Checker of power, watch, detach and debounce relations at the detector ports.
// Bound to tccad_top by the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tccad_top_props
	import tccad_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = 4
) (
	input wire logic        i_clk_sys,
	input wire logic        i_reset,
	input wire logic        i_role_source,
	input wire logic        i_pin_a_below_sink,
	input wire logic        i_pin_a_below_cable,
	input wire logic        i_pin_b_below_sink,
	input wire logic        i_pin_b_below_cable,
	input wire logic        i_vbus_present,
	input wire logic        o_vbus_power_en,
	input wire logic        o_vconn_on_pin_a,
	input wire logic        o_vconn_on_pin_b,
	input wire tccad_conn_t o_conn_state,
	input wire logic        o_watch_pin_a,
	input wire logic        o_watch_pin_b,
	input wire logic        o_orientation_b,
	input wire logic        o_detach_event
);
	logic [3:0] ins_q;
	int         quiet;
	// Cycles since any comparator input last moved
	always_ff @(posedge i_clk_sys) begin
		ins_q <= {i_pin_a_below_sink, i_pin_a_below_cable, i_pin_b_below_sink, i_pin_b_below_cable};
		if (i_reset || ins_q != {i_pin_a_below_sink, i_pin_a_below_cable, i_pin_b_below_sink, i_pin_b_below_cable})
			quiet <= 0;
		else
			quiet <= quiet + 1;
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_sink_hold;
		(!i_role_source && i_vbus_present) [*8];
	endsequence
	property p_idle;
		i_role_source && o_conn_state == TCCAD_CONN_NONE |-> !o_vbus_power_en && !o_vconn_on_pin_a
			&& !o_vconn_on_pin_b && o_watch_pin_a && o_watch_pin_b;
	endproperty
	a_idle: assert property (p_idle) else $error("power or watch wrong while idle");
	property p_sink;
		o_conn_state == TCCAD_CONN_SINK |-> o_vbus_power_en && !o_vconn_on_pin_a && !o_vconn_on_pin_b
			&& o_watch_pin_a != o_watch_pin_b;
	endproperty
	a_sink: assert property (p_sink) else $error("sink attach outputs wrong");
	property p_orient;
		o_conn_state == TCCAD_CONN_SINK |-> o_watch_pin_b == o_orientation_b;
	endproperty
	a_orient: assert property (p_orient) else $error("orientation disagrees with watched pin");
	property p_cable;
		o_conn_state == TCCAD_CONN_CABLE_ONLY |-> !o_vbus_power_en && !o_vconn_on_pin_a
			&& !o_vconn_on_pin_b && o_watch_pin_a && o_watch_pin_b;
	endproperty
	a_cable: assert property (p_cable) else $error("cable only outputs wrong");
	property p_vconn;
		o_conn_state == TCCAD_CONN_CABLE_SINK |-> o_vbus_power_en && o_vconn_on_pin_a == o_watch_pin_b
			&& o_vconn_on_pin_b == o_watch_pin_a && o_watch_pin_a != o_watch_pin_b;
	endproperty
	a_vconn: assert property (p_vconn) else $error("vconn pin or watch wrong");
	property p_acc;
		o_conn_state inside {TCCAD_CONN_DEBUG_ACC, TCCAD_CONN_AUDIO_ACC} |-> o_watch_pin_a && o_watch_pin_b
			&& !o_vconn_on_pin_a && !o_vconn_on_pin_b;
	endproperty
	a_acc: assert property (p_acc) else $error("accessory outputs wrong");
	property p_detach;
		o_conn_state == TCCAD_CONN_NONE && $past(o_conn_state) != TCCAD_CONN_NONE |-> o_detach_event;
	endproperty
	a_detach: assert property (p_detach) else $error("detach without event pulse");
	property p_debounce;
		$changed(o_conn_state) && o_conn_state != TCCAD_CONN_NONE && i_role_source |-> quiet >= DEBOUNCE_CYCLES;
	endproperty
	a_debounce: assert property (p_debounce) else $error("state moved before inputs settled");
	property p_sink_role;
		s_sink_hold |-> o_conn_state == TCCAD_CONN_SOURCE && !o_vbus_power_en;
	endproperty
	a_sink_role: assert property (p_sink_role) else $error("sink role attach wrong");
endmodule
`default_nettype wire

// File: verif/tccad_top_bench.sv
// Self-checking bench: source table with random pairs, debounce, detach and sink role.
// Needs the cable model and the checker; one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tccad_top_bench;
	import tccad_pkg::*;
	localparam int DEB = 4;
	logic        clk, rst, ce, role, trim, rmdb, vbus, a_s, a_c, b_s, b_c;
	logic        pu_en, trim_en, db_off, vbus_en, va, vb, wa, wb, det, ori;
	logic [1:0]  adv, lvl, plv, adv_sel, part;
	tccad_term_t ta, tb;
	tccad_conn_t conn, e;
	int          err_total, n_tests, n_det, k;
	tccad_cable_model i_tccad_cable_model (.i_term_a(ta), .i_term_b(tb), .i_src_level(lvl),
		.o_a_below_sink(a_s), .o_a_below_cable(a_c), .o_b_below_sink(b_s), .o_b_below_cable(b_c),
		.o_pullup_level(plv));
	tccad_top #(.DEBOUNCE_CYCLES(DEB)) i_tccad_top (.i_clk_sys(clk), .i_reset(rst), .i_ce(ce),
		.i_role_source(role), .i_adv_level(adv), .i_use_trimmed_pulldown(trim),
		.i_remove_deadbattery_pulldown(rmdb), .i_pin_a_below_sink(a_s), .i_pin_a_below_cable(a_c),
		.i_pin_b_below_sink(b_s), .i_pin_b_below_cable(b_c), .i_vbus_present(vbus),
		.i_sink_pullup_level(plv), .o_adv_select(adv_sel), .o_source_pullup_current_en(pu_en),
		.o_trimmed_sink_pulldown_en(trim_en), .o_deadbattery_sink_pulldown_off(db_off),
		.o_vbus_power_en(vbus_en), .o_vconn_on_pin_a(va), .o_vconn_on_pin_b(vb), .o_conn_state(conn),
		.o_watch_pin_a(wa), .o_watch_pin_b(wb), .o_orientation_b(ori), .o_partner_adv_level(part),
		.o_detach_event(det));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (det === 1'b1) n_det++;
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Packed {state, vbus, vconn a, vconn b, watch a, watch b}
	function automatic logic [7:0] f_exp(tccad_term_t a, tccad_term_t b);
		logic        sa, sb, ca, cb;
		tccad_conn_t c;
		sa = (a == TCCAD_TERM_RD);
		sb = (b == TCCAD_TERM_RD);
		ca = (a == TCCAD_TERM_RA);
		cb = (b == TCCAD_TERM_RA);
		if (sa && sb) c = TCCAD_CONN_DEBUG_ACC;
		else if (ca && cb) c = TCCAD_CONN_AUDIO_ACC;
		else if (sa || sb) c = (ca || cb) ? TCCAD_CONN_CABLE_SINK : TCCAD_CONN_SINK;
		else c = (ca || cb) ? TCCAD_CONN_CABLE_ONLY : TCCAD_CONN_NONE;
		return {c, sa ^ sb, ca & sb, sa & cb, sa | !sb, sb | !sa};
	endfunction
	task src(input tccad_term_t a, input tccad_term_t b);
		logic [7:0] x;
		ta = a;
		tb = b;
		adv = 2'($urandom % 3);
		x = f_exp(a, b);
		wt(20);
		chk({conn, vbus_en, va, vb, wa, wb}, x);
		chk({adv_sel, pu_en}, {adv, 1'b1});
		if ((a == TCCAD_TERM_RD) != (b == TCCAD_TERM_RD)) chk(ori, b == TCCAD_TERM_RD);
		e = tccad_conn_t'(x[7:5]);
		k = n_det;
		ta = TCCAD_TERM_OPEN;
		tb = TCCAD_TERM_OPEN;
		wt(20);
		chk({conn, vbus_en, va, vb}, {TCCAD_CONN_NONE, 3'h0});
		chk(16'(n_det - k), {15'h0, e != TCCAD_CONN_NONE});
	endtask
	initial begin
		{rst, role, trim, rmdb, vbus, adv, lvl} = 9'h180;
		ce = 1;
		{ta, tb} = {TCCAD_TERM_OPEN, TCCAD_TERM_OPEN};
		{err_total, n_tests, n_det} = 0;
		void'($urandom(32'hB5D7));
		wt(12);
		rst = 0;
		wt(2);
		chk({conn, vbus_en, wa, wb}, {TCCAD_CONN_NONE, 3'h3});
		for (int i = 0; i < 21; i++)
			src(tccad_term_t'(i < 9 ? i % 3 : $urandom % 3), tccad_term_t'(i < 9 ? i / 3 : $urandom % 3));
		$display("source table test done");
		// A pulse shorter than the debounce must leave no trace
		ta = TCCAD_TERM_RD;
		wt(DEB - 2);
		ta = TCCAD_TERM_OPEN;
		wt(20);
		chk({conn, vbus_en}, {TCCAD_CONN_NONE, 1'b0});
		$display("debounce test done");
		// Enable low freezes all registered outputs; a mid-run reset drops the attach with no detach pulse
		ce = 0;
		ta = TCCAD_TERM_RD;
		wt(20);
		chk({conn, vbus_en}, {TCCAD_CONN_NONE, 1'b0});
		ce = 1;
		wt(20);
		chk({conn, vbus_en, wa, wb}, {TCCAD_CONN_SINK, 3'h6});
		k = n_det;
		rst = 1;
		wt(2);
		rst = 0;
		chk({conn, vbus_en, wa, wb, det}, {TCCAD_CONN_NONE, 4'h6});
		wt(20);
		chk(conn, TCCAD_CONN_SINK);
		chk(16'(n_det - k), 16'h0);
		ta = TCCAD_TERM_OPEN;
		wt(20);
		chk(16'(n_det - k), 16'h1);
		$display("enable and reset test done");
		role = 0;
		for (int i = 0; i < 4; i++) begin
			lvl = 2'($urandom % 3);
			{trim, rmdb} = 2'($urandom);
			vbus = 1;
			wt(12);
			chk({conn, part, vbus_en}, {TCCAD_CONN_SOURCE, lvl, 1'b0});
			chk({trim_en, db_off, pu_en}, {trim, trim | rmdb, 1'b0});
			vbus = 0;
			wt(12);
			chk({conn, part}, {TCCAD_CONN_NONE, 2'h0});
		end
		$display("sink role test done");
		give_verdict;
	end
	initial begin
		#80000;
		err_total++;
		give_verdict;
	end
endmodule
bind tccad_top tccad_top_props #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_tccad_top_props (
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_role_source(i_role_source),
	.i_pin_a_below_sink(i_pin_a_below_sink), .i_pin_a_below_cable(i_pin_a_below_cable),
	.i_pin_b_below_sink(i_pin_b_below_sink), .i_pin_b_below_cable(i_pin_b_below_cable),
	.i_vbus_present(i_vbus_present), .o_vbus_power_en(o_vbus_power_en), .o_vconn_on_pin_a(o_vconn_on_pin_a),
	.o_vconn_on_pin_b(o_vconn_on_pin_b), .o_conn_state(o_conn_state), .o_watch_pin_a(o_watch_pin_a),
	.o_watch_pin_b(o_watch_pin_b), .o_orientation_b(o_orientation_b), .o_detach_event(o_detach_event));
`default_nettype wire
